// ### hdl/ddsl_pkg.sv
// Shared constants and types for the dual DAC serial load control
package ddsl_pkg;

	// ----------------------------------------------------------------
	// Serial word layout
	// ----------------------------------------------------------------
	localparam int          CODE_W       = 14;    // Code width per channel
	localparam int          WORD_W       = 16;    // Serial word width
	localparam int          ADDR_HI_POS  = 15;    // channel_addr_hi position
	localparam int          ADDR_LO_POS  = 14;    // channel_addr_lo position
	localparam int          CODE_MSB_POS = 13;    // Top of code_bits

	// ----------------------------------------------------------------
	// Preset and reset values
	// ----------------------------------------------------------------
	localparam logic [13:0] ZERO_CODE    = 14'h0000;  // Zero scale
	localparam logic [13:0] HALF_CODE    = 14'h2000;  // Half scale

	// ----------------------------------------------------------------
	// Channel address decode
	// ----------------------------------------------------------------
	localparam logic [1:0]  ADDR_NONE    = 2'h0;  // No channel
	localparam logic [1:0]  ADDR_A       = 2'h1;  // Channel A only
	localparam logic [1:0]  ADDR_B       = 2'h2;  // Channel B only
	localparam logic [1:0]  ADDR_AB      = 2'h3;  // Both channels

	// ----------------------------------------------------------------
	// Control sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h1,
		ST_FRAME  = 3'h2,
		ST_COMMIT = 3'h4
	} ddsl_state_t;

endpackage

// ### hdl/ddsl_link_if.sv
// Carrier for the serial word from the link domain to the control logic
`timescale 1ns/100ps
`default_nettype none

interface ddsl_link_if #(parameter int WORD_W = ddsl_pkg::WORD_W);
	logic [WORD_W-1:0] word;    // Shift register contents, stable while chip-select is high

	modport shifter (output word);
	modport ctrl    (input word);
endinterface

`default_nettype wire

// ### hdl/ddsl_shift.sv
// Serial shift register running on the serial clock
`timescale 1ns/100ps
`default_nettype none

module ddsl_shift #(
	parameter int WORD_W = ddsl_pkg::WORD_W
) (
	input  wire logic    serial_clk,       // Serial clock from the host
	input  wire logic    cs_n,             // Chip-select, low enables shifting
	input  wire logic    serial_data_in,   // Serial data, MSB first
	ddsl_link_if.shifter lnk               // Word towards the control logic
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [WORD_W-1:0] shift_reg;
	} ddsl_shift_st_t;

	ddsl_shift_st_t st_ff;
	ddsl_shift_st_t nxt_st;

	// Next value: shift only inside a frame; no reset, since preset leaves it alone
	always_comb begin
		nxt_st = st_ff;
		if (!cs_n) begin
			nxt_st.shift_reg = {st_ff.shift_reg[WORD_W-2:0], serial_data_in};
		end
	end

	// Register; the clock may stop between frames, nothing here needs it to run
	always_ff @(posedge serial_clk) begin
		st_ff <= nxt_st;
	end

	assign lnk.word = st_ff.shift_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_SHIFT_IN: assert property (@(posedge serial_clk)
		!cs_n |=> st_ff.shift_reg[0] == $past(serial_data_in))
		else $error("Serial bit not shifted in");

	AST_SHIFT_MSB_FIRST: assert property (@(posedge serial_clk)
		!cs_n |=> st_ff.shift_reg[WORD_W-1:1] === $past(st_ff.shift_reg[WORD_W-2:0]))
		else $error("Shift register did not advance toward the top bit");

	AST_SHIFT_IDLE: assert property (@(posedge serial_clk)
		cs_n |=> $stable(st_ff.shift_reg))
		else $error("Shift register moved while chip-select high");

endmodule

`default_nettype wire

// ### hdl/ddsl_top.sv
// Control logic of a dual 14-bit DAC: serial load, double buffering, preset
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Select low: each serial clock shifts one bit
// - Select rising edge copies code to inputs
// - Address 00 none, 01 A, 10 B, 11 both
// - Preset low, level 0: input and DAC registers zero
// - Preset low, level 1: input and DAC registers half-scale
// - Preset needs no serial clock; may tie high
// - Power-up reset loads zero or half-scale
// - After reset DAC holds until load strobe low
// - Load strobe low: DAC follows input registers
// - Select high: serial clock ignored
// - Word is 16 bits, address then code
// - Only the last 16 bits count
module ddsl_top (
	input  wire logic        sys_clk,         // System clock, 50 MHz
	input  wire logic        srst,            // Synchronous reset, active high
	input  wire logic        serial_clk,      // Serial link clock
	input  wire logic        cs_n,            // Chip-select, active low
	input  wire logic        serial_data_in,  // Serial data
	input  wire logic        load_strobe_n,   // DAC load strobe, active low
	input  wire logic        preset_n,        // Preset, active low
	input  wire logic        level_sel,       // Preset level, 1 = half scale
	output logic      [13:0] dac_code_a,      // DAC register A
	output logic      [13:0] dac_code_b,      // DAC register B
	output logic      [13:0] in_code_a,       // Input register A
	output logic      [13:0] in_code_b,       // Input register B
	output logic             frame_active,    // Serial frame in progress
	output logic             update_pulse     // One-cycle pulse in the same cycle as an input load
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                 cs_s1;      // Chip-select synchroniser
		logic                 cs_s2;
		logic                 cs_s3;      // Delayed copy for edge detect
		logic                 ld_s1;      // Load strobe synchroniser
		logic                 ld_s2;
		logic                 rs_s1;      // Preset synchroniser
		logic                 rs_s2;
		logic                 lv_s1;      // Level select synchroniser
		logic                 lv_s2;
		ddsl_pkg::ddsl_state_t state;
		logic [13:0]          in_a;
		logic [13:0]          in_b;
		logic [13:0]          dac_a;
		logic [13:0]          dac_b;
		logic                 frame_act;
		logic                 upd;
		logic [1:0]           rst_q;      // Reset history for the settle reload
	} ddsl_top_st_t;

	ddsl_top_st_t st_ff;
	ddsl_top_st_t nxt_st;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Value forced by preset or power-up reset
	function automatic logic [13:0] preset_code(input logic lvl);
		return lvl ? ddsl_pkg::HALF_CODE : ddsl_pkg::ZERO_CODE;
	endfunction

	// Channel hits from the two address bits, {b, a}
	function automatic logic [1:0] addr_hits(input logic [1:0] addr);
		logic [1:0] hit;
		hit = 2'h0;
		unique case (addr)
			ddsl_pkg::ADDR_NONE: hit = 2'h0;
			ddsl_pkg::ADDR_A:    hit = 2'h1;
			ddsl_pkg::ADDR_B:    hit = 2'h2;
			ddsl_pkg::ADDR_AB:   hit = 2'h3;
		endcase
		return hit;
	endfunction

	// ----------------------------------------------------------------
	// Link domain
	// ----------------------------------------------------------------
	ddsl_link_if #(.WORD_W(ddsl_pkg::WORD_W)) lnk ();

	ddsl_shift #(
		.WORD_W         (ddsl_pkg::WORD_W)
	) u_shift (
		.serial_clk     (serial_clk),
		.cs_n           (cs_n),
		.serial_data_in (serial_data_in),
		.lnk            (lnk)
	);

	// Address and code fields of the captured word
	logic [1:0]  word_addr;
	logic [13:0] word_code;
	logic [1:0]  word_hit;

	assign word_addr = {lnk.word[ddsl_pkg::ADDR_HI_POS], lnk.word[ddsl_pkg::ADDR_LO_POS]};
	assign word_code = lnk.word[ddsl_pkg::CODE_MSB_POS:0];
	assign word_hit  = addr_hits(word_addr);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// The word is read only in COMMIT: chip-select has then been high for three
	// edges, so the shift register is frozen and safe to sample across domains.
	// Trade-off: a chip-select high gap shorter than three system clocks can let the next frame shift the word before it is read.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.upd = 1'b0;

		// Pin synchronisers, two stages each
		nxt_st.cs_s1 = cs_n;
		nxt_st.cs_s2 = st_ff.cs_s1;
		nxt_st.cs_s3 = st_ff.cs_s2;
		nxt_st.ld_s1 = load_strobe_n;
		nxt_st.ld_s2 = st_ff.ld_s1;
		nxt_st.rs_s1 = preset_n;
		nxt_st.rs_s2 = st_ff.rs_s1;
		nxt_st.lv_s1 = level_sel;
		nxt_st.lv_s2 = st_ff.lv_s1;

		// Reset history: the level synchroniser is stale or unknown during a short
		// reset, so the level is loaded again on the two edges after release
		nxt_st.rst_q = {st_ff.rst_q[0], srst};

		// Frame sequencer
		unique case (st_ff.state)
			ddsl_pkg::ST_IDLE: begin
				if (!st_ff.cs_s2) begin
					nxt_st.state = ddsl_pkg::ST_FRAME;
				end
			end
			ddsl_pkg::ST_FRAME: begin
				if (st_ff.cs_s2 && !st_ff.cs_s3) begin
					nxt_st.state = ddsl_pkg::ST_COMMIT;
				end
			end
			ddsl_pkg::ST_COMMIT: begin
				nxt_st.state = st_ff.cs_s2 ? ddsl_pkg::ST_IDLE : ddsl_pkg::ST_FRAME;
			end
			default: begin
				nxt_st.state = ddsl_pkg::ST_IDLE;
			end
		endcase
		nxt_st.frame_act = (nxt_st.state == ddsl_pkg::ST_FRAME);

		if (st_ff.state == ddsl_pkg::ST_COMMIT) begin
			if (word_hit[0]) begin
				nxt_st.in_a = word_code;
			end
			if (word_hit[1]) begin
				nxt_st.in_b = word_code;
			end
			nxt_st.upd = |word_hit;
		end

		if (!st_ff.ld_s2) begin
			nxt_st.dac_a = st_ff.in_a;
			nxt_st.dac_b = st_ff.in_b;
		end

		if (!st_ff.rs_s2) begin
			nxt_st.in_a  = preset_code(st_ff.lv_s2);
			nxt_st.in_b  = preset_code(st_ff.lv_s2);
			nxt_st.dac_a = preset_code(st_ff.lv_s2);
			nxt_st.dac_b = preset_code(st_ff.lv_s2);
			nxt_st.upd   = 1'b0;
		end

		// held until a load
		// Reload continues for two edges after release, so a two-cycle reset lands
		if (srst || st_ff.rst_q != 2'h0) begin
			nxt_st.state     = ddsl_pkg::ST_IDLE;
			nxt_st.frame_act = 1'b0;
			nxt_st.upd       = 1'b0;
			nxt_st.in_a      = preset_code(st_ff.lv_s2);
			nxt_st.in_b      = preset_code(st_ff.lv_s2);
			nxt_st.dac_a     = preset_code(st_ff.lv_s2);
			nxt_st.dac_b     = preset_code(st_ff.lv_s2);
		end
	end

	// Single state register; synchronisers keep sampling through reset
	always_ff @(posedge sys_clk) begin
		st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign dac_code_a   = st_ff.dac_a;
	assign dac_code_b   = st_ff.dac_b;
	assign in_code_a    = st_ff.in_a;
	assign in_code_b    = st_ff.in_b;
	assign frame_active = st_ff.frame_act;
	assign update_pulse = st_ff.upd;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_PRESET_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
		(!st_ff.rs_s2 && !st_ff.lv_s2) |=>
			(st_ff.in_a == ddsl_pkg::ZERO_CODE) && (st_ff.in_b == ddsl_pkg::ZERO_CODE) &&
			(st_ff.dac_a == ddsl_pkg::ZERO_CODE) && (st_ff.dac_b == ddsl_pkg::ZERO_CODE))
		else $error("Zero preset not applied");

	AST_PRESET_HALF: assert property (@(posedge sys_clk) disable iff (srst)
		(!st_ff.rs_s2 && st_ff.lv_s2) |=>
			(st_ff.in_a == ddsl_pkg::HALF_CODE) && (st_ff.in_b == ddsl_pkg::HALF_CODE) &&
			(st_ff.dac_a == ddsl_pkg::HALF_CODE) && (st_ff.dac_b == ddsl_pkg::HALF_CODE))
		else $error("Half-scale preset not applied");

	AST_PRESET_PIN: assert property (@(posedge sys_clk) disable iff (srst)
		(!preset_n && !level_sel) [*3] |=> (st_ff.dac_a == ddsl_pkg::ZERO_CODE))
		else $error("Preset pin did not reach the DAC register in time");

	AST_POWER_UP: assert property (@(posedge sys_clk)
		st_ff.rst_q[1] |=> (st_ff.dac_a == preset_code($past(st_ff.lv_s2))) &&
			(st_ff.in_b == preset_code($past(st_ff.lv_s2))) && (st_ff.state == ddsl_pkg::ST_IDLE))
		else $error("Power-up reset level wrong");

	AST_INPUT_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state != ddsl_pkg::ST_COMMIT && st_ff.rs_s2 && st_ff.rst_q == 2'h0) |=>
			$stable(st_ff.in_a) && $stable(st_ff.in_b))
		else $error("Input register changed without a load");

	AST_COMMIT_EDGE: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state == ddsl_pkg::ST_FRAME && $rose(st_ff.cs_s2)) |=>
			(st_ff.state == ddsl_pkg::ST_COMMIT) ##1 (st_ff.state != ddsl_pkg::ST_COMMIT))
		else $error("Select rising edge did not give exactly one commit");

	AST_ADDR_A: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state == ddsl_pkg::ST_COMMIT && st_ff.rs_s2 && word_addr == ddsl_pkg::ADDR_A) |=>
			(st_ff.in_a == $past(word_code)) && $stable(st_ff.in_b) && st_ff.upd)
		else $error("Address 01 did not load channel A alone");

	AST_ADDR_B: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state == ddsl_pkg::ST_COMMIT && st_ff.rs_s2 && word_addr == ddsl_pkg::ADDR_B) |=>
			(st_ff.in_b == $past(word_code)) && $stable(st_ff.in_a))
		else $error("Address 10 did not load channel B alone");

	AST_ADDR_BOTH: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state == ddsl_pkg::ST_COMMIT && st_ff.rs_s2 && word_addr == ddsl_pkg::ADDR_AB) |=>
			(st_ff.in_a == $past(word_code)) && (st_ff.in_b == $past(word_code)))
		else $error("Address 11 did not load both channels");

	AST_ADDR_NONE: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state == ddsl_pkg::ST_COMMIT && st_ff.rs_s2 && word_addr == ddsl_pkg::ADDR_NONE) |=>
			$stable(st_ff.in_a) && $stable(st_ff.in_b) && !st_ff.upd)
		else $error("Address 00 changed an input register");

	AST_TRANSPARENT: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.rs_s2 && !st_ff.ld_s2 && st_ff.rst_q == 2'h0) |=>
			(st_ff.dac_a == $past(st_ff.in_a)) && (st_ff.dac_b == $past(st_ff.in_b)))
		else $error("DAC register not following input while strobe low");

	AST_LATCHED: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.rs_s2 && st_ff.ld_s2 && st_ff.rst_q == 2'h0) |=>
			$stable(st_ff.dac_a) && $stable(st_ff.dac_b))
		else $error("DAC register moved while strobe high");

	AST_PRESET_PIN_HALF: assert property (@(posedge sys_clk) disable iff (srst)
		(!preset_n && level_sel) [*3] |=> (st_ff.dac_b == ddsl_pkg::HALF_CODE))
		else $error("Half-scale preset pin did not reach the DAC register in time");

	AST_PULSE_SINGLE: assert property (@(posedge sys_clk) disable iff (srst)
		st_ff.upd |=> !st_ff.upd)
		else $error("Update pulse lasted more than one cycle");

	AST_UPD_ONLY_COMMIT: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state != ddsl_pkg::ST_COMMIT) |=> !st_ff.upd)
		else $error("Update pulse without a commit");

	AST_FRAME_ENTRY: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state == ddsl_pkg::ST_IDLE && !st_ff.cs_s2 && st_ff.rst_q == 2'h0) |=>
			(st_ff.state == ddsl_pkg::ST_FRAME) && st_ff.frame_act)
		else $error("Low chip-select did not open a frame");

	AST_SELECT_HIGH: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.state == ddsl_pkg::ST_IDLE && st_ff.cs_s2) |=>
			(st_ff.state == ddsl_pkg::ST_IDLE) && !st_ff.frame_act)
		else $error("Frame opened while chip-select high");

	AST_RESET_SETTLE: assert property (@(posedge sys_clk) disable iff (srst)
		(st_ff.rst_q != 2'h0) |=> !st_ff.upd && !st_ff.frame_act && (st_ff.state == ddsl_pkg::ST_IDLE))
		else $error("Activity during the reset settle cycles");

endmodule

`default_nettype wire

// ### testbench/ddsl_host_model.sv
// Host model that drives the three-wire serial port
`timescale 1ns/100ps
`default_nettype none

module ddsl_host_model (
	output var logic serial_clk,      // Serial clock, still outside frames except during stray
	output var logic cs_n,            // Chip-select, active low
	output var logic serial_data_in   // Serial data towards the device
);
	// Idle levels at time zero
	initial begin
		serial_clk     = 1'b0;
		cs_n           = 1'b1;
		serial_data_in = 1'b0;
	end

	task automatic put(input logic b);
		serial_data_in = b;
		#40 serial_clk = 1'b1;
		#40 serial_clk = 1'b0;
	endtask

	// MSB first framing
	// Mode 0 sends the word, 1 a byte then the word, 2 the byte alone
	task automatic send(input logic [15:0] w, input logic [7:0] pre, input int mode);
		int i;
		cs_n = 1'b0;
		#27;
		if (mode != 0) for (i = 7; i >= 0; i--) put(pre[i]);
		if (mode != 2) for (i = 15; i >= 0; i--) put(w[i]);
		#23 cs_n = 1'b1;
		// Released data line must not keep showing the last bit
		#10 serial_data_in = ~serial_data_in;
	endtask

	// Clock edges with chip-select high, only when a scenario asks
	task automatic stray(input int n);
		int i;
		for (i = 0; i < n; i++) begin
			put(~serial_data_in);
		end
	endtask
endmodule

`default_nettype wire

// ### testbench/ddsl_top_tb.sv
// Self-checking bench of the dual DAC serial load control
`timescale 1ns/100ps
`default_nettype none

module ddsl_top_tb;
	logic        sys_clk;
	logic        srst;
	logic        load_strobe_n;
	logic        preset_n;
	logic        level_sel;
	wire         serial_clk;
	wire         cs_n;
	wire         serial_data_in;
	logic [13:0] dac_code_a;
	logic [13:0] dac_code_b;
	logic [13:0] in_code_a;
	logic [13:0] in_code_b;
	logic        frame_active;
	logic        update_pulse;
	int          miscompares;
	int          samples_checked;
	logic [31:0] rng;
	int          m_in_a;
	int          m_in_b;
	int          m_dac_a;
	int          m_dac_b;
	bit          strobe_low;
	bit          sr_q[$];
	int          a;

	ddsl_host_model host (.serial_clk(serial_clk), .cs_n(cs_n), .serial_data_in(serial_data_in));

	ddsl_top dut (.sys_clk(sys_clk), .srst(srst), .serial_clk(serial_clk), .cs_n(cs_n),
		.serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n), .preset_n(preset_n),
		.level_sel(level_sel), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b), .in_code_a(in_code_a),
		.in_code_b(in_code_b), .frame_active(frame_active), .update_pulse(update_pulse));

	// ----------------------------------------------------------------
	// Clock, random source, checking
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Input registers and DAC registers against the model
	task automatic cmp_all();
		check("in_code_a", in_code_a, m_in_a[13:0]);
		check("in_code_b", in_code_b, m_in_b[13:0]);
		check("dac_code_a", dac_code_a, m_dac_a[13:0]);
		check("dac_code_b", dac_code_b, m_dac_b[13:0]);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenario tasks
	// ----------------------------------------------------------------
	// Model keeps the last sixteen bits sent, across frames, and reads them at commit
	task automatic frame(input int mode, input logic [15:0] w, input logic [7:0] pre);
		int i;
		int n;
		logic [15:0] word;
		logic        seen_act;
		// Look at the frame flag while the host is still shifting
		fork
			host.send(w, pre, mode);
			begin
				repeat (10) @(negedge sys_clk);
				seen_act = frame_active;
			end
		join
		check("frame_active", {13'h0, seen_act}, 14'h0001);
		if (mode != 0) for (i = 7; i >= 0; i--) sr_q.push_back(pre[i]);
		if (mode != 2) for (i = 15; i >= 0; i--) sr_q.push_back(w[i]);
		while (sr_q.size() > 16) void'(sr_q.pop_front());
		for (i = 0; i < 16; i++) word[15 - i] = sr_q[i];
		if (word[14]) m_in_a = word[13:0];
		if (word[15]) m_in_b = word[13:0];
		// Count pulse cycles: one for a channel address, none for address 00
		n = 0;
		for (i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			#1;
			if (update_pulse === 1'b1) n++;
		end
		check("update_pulse", n[13:0], {13'h0, word[15:14] != 2'h0});
		check("frame_active", {13'h0, frame_active}, 14'h0000);
		repeat (6) @(negedge sys_clk);
		if (strobe_low) begin
			m_dac_a = m_in_a;
			m_dac_b = m_in_b;
		end
		cmp_all();
	endtask

	task automatic set_strobe(input logic b);
		@(negedge sys_clk) load_strobe_n = b;
		strobe_low = !b;
		repeat (5) @(negedge sys_clk);
		if (strobe_low) begin
			m_dac_a = m_in_a;
			m_dac_b = m_in_b;
		end
		cmp_all();
	endtask

	// Serial clock stays still throughout, so preset needs none
	task automatic do_preset(input logic lvl);
		@(negedge sys_clk) level_sel = lvl;
		repeat (3) @(negedge sys_clk);
		preset_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		m_in_a = lvl ? 14'h2000 : 14'h0000;
		m_in_b = m_in_a;
		m_dac_a = m_in_a;
		m_dac_b = m_in_a;
		cmp_all();
		preset_n = 1'b1;
		repeat (5) @(negedge sys_clk);
		cmp_all();
	endtask

	// Reset held two cycles; called at time zero or at a falling edge
	task automatic do_reset(input logic lvl);
		level_sel = lvl;
		srst = 1'b1;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		m_in_a = lvl ? 14'h2000 : 14'h0000;
		m_in_b = m_in_a;
		m_dac_a = m_in_a;
		m_dac_b = m_in_a;
		repeat (2) @(negedge sys_clk);
		cmp_all();
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		load_strobe_n = 1'b1;
		preset_n = 1'b1;
		level_sel = 1'b1;
		miscompares = 0;
		samples_checked = 0;
		strobe_low = 1'b0;
		rng = 32'h2ac38b1b;
		do_reset(1'b1);
		// Every address code with the DAC registers latched
		for (a = 0; a < 4; a++) begin
			rng = xs(rng);
			frame(0, {a[1:0], rng[13:0]}, 8'h00);
		end
		set_strobe(1'b0);
		rng = xs(rng);
		frame(0, {2'h3, rng[13:0]}, 8'h00);
		set_strobe(1'b1);
		rng = xs(rng);
		frame(0, {2'h1, rng[13:0]}, 8'h00);
		rng = xs(rng);
		// Extra leading byte must be pushed out
		frame(1, {2'h2, rng[13:0]}, rng[23:16]);
		host.stray(5);
		rng = xs(rng);
		// Short frame shows stray edges were not shifted in
		frame(2, 16'h0000, rng[7:0]);
		do_preset(1'b0);
		do_preset(1'b1);
		rng = xs(rng);
		// Short frame shows preset left the shift register alone
		frame(2, 16'h0000, rng[7:0]);
		do_reset(1'b0);
		wrap_up();
	end

	// Whole run is about fifteen microseconds
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end
endmodule

`default_nettype wire
